// ==== include/csfs_pkg.sv ====
// Constants, states and channel indices for the converter sequencer.
// Assumes one 20 MHz system clock and synchronous analog status inputs.
//
// How it works
// - Main and both auxiliary channels ramp their reference from zero to full over 4096 cycles.
// - The buck ramp finishes in 2048 oscillator cycles, half the others.
// - The boost channel starts with no counted reference ramp.
// - Any channel out of regulation for 100,000 cycles latches all outputs off.
// - The off latch clears only through boost enable or a power cycle.
// - Fault counting is suppressed while a channel runs its turn-on ramp.
// - Boost rail under its lockout level shuts main, buck and both auxiliaries at once.
// - After lockout the boost keeps retrying its start.
// - A boost retry still out of regulation after the ramp interval faults again.
// - The reference output runs only with boost enabled and rail above lockout.
// - Each channel runs on a high level at its own enable input.
// - Buck, main and both auxiliaries stay off until the boost regulates.
// - Startup oscillator drives the boost below lockout, then PWM takes over.
// - Comparator high fires a 200 ns discharge one-shot, one per oscillator period.
// - Buck good pulls low after buck ramp; floats in shutdown, overload, thermal.
// - Overload flag pulls low normally and floats once overload protection latched.

package csfs_pkg;

    // ------------------------------------------------------------
    // Channel indices
    // ------------------------------------------------------------
    localparam int NUM_CH    = 5;
    localparam int CH_BOOST  = 0;
    localparam int CH_MAIN   = 1;
    localparam int CH_BUCK   = 2;
    localparam int CH_AUX_A  = 3;
    localparam int CH_AUX_B  = 4;

    // ------------------------------------------------------------
    // Reference ramp and timing
    // ------------------------------------------------------------
    localparam int REF_W           = 12;
    localparam int SS_CYCLES       = 4096;
    localparam int BUCK_SS_CYCLES  = 2048;
    localparam int FAULT_CYCLES    = 100000;
    localparam int CLK_PERIOD_NS   = 50;
    localparam int ONESHOT_NS      = 200;
    localparam int ONESHOT_CYC     = (ONESHOT_NS / CLK_PERIOD_NS < 1) ? 1 : ONESHOT_NS / CLK_PERIOD_NS;
    localparam int SHOT_W          = 4;

    // ------------------------------------------------------------
    // Boost supervisor states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        BST_OFF   = 3'h0,
        BST_START = 3'h1,
        BST_WAIT  = 3'h2,
        BST_RUN   = 3'h3,
        BST_LATCH = 3'h4
    } csfs_state_t;

endpackage

// ==== hw/csfs_soft_start.sv ====
// Counted reference ramp for one soft-started channel.
// Assumes tick_in is a one-cycle pulse per oscillator period.
`timescale 1ns/1ns

module csfs_soft_start #(
    parameter int CYCLES = 4096,
    parameter int REF_W  = 12
) (
    input  wire logic             clk_in,
    input  wire logic             nrst_in,
    input  wire logic             tick_in,
    input  wire logic             run_in,
    output logic [REF_W-1:0]      level_out,
    output logic                  done_out
);
    localparam int CNT_W = $clog2(CYCLES + 1);
    localparam int STEP  = (1 << REF_W) / CYCLES;

    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic [REF_W-1:0] next_level;
    logic             at_end;

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (CYCLES < 2 || CYCLES > (1 << REF_W) || (CYCLES & (CYCLES - 1)) != 0) begin : g_bad
        $error("soft-start length must be a power of two within the reference range");
    end

    // ------------------------------------------------------------
    // Ramp counter
    // ------------------------------------------------------------
    // Off restarts the ramp from zero on every enable
    assign at_end     = (count == CYCLES[CNT_W-1:0]);
    assign next_count = !run_in ? '0 : (tick_in && !at_end) ? count + 1'b1 : count;
    assign next_level = (next_count == CYCLES[CNT_W-1:0]) ? {REF_W{1'b1}}
                      : REF_W'(next_count * STEP);

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            count     <= '0;
            level_out <= '0;
            done_out  <= 1'b0;
        end else begin
            count     <= next_count;
            level_out <= next_level;
            done_out  <= (next_count == CYCLES[CNT_W-1:0]);
        end
    end

    a_ramp_rising: assert property (@(posedge clk_in) disable iff (!nrst_in)
        run_in && $past(run_in) |-> level_out >= $past(level_out))
        else $error("reference ramp fell while running");
    a_ramp_zero: assert property (@(posedge clk_in) disable iff (!nrst_in)
        !run_in |=> level_out == '0 && !done_out)
        else $error("reference not zero when channel off");

endmodule

// ==== hw/csfs_fault_timer.sv ====
// Out-of-regulation delay counter for one channel.
// Assumes tick_in pulses once per oscillator period.
`timescale 1ns/1ns

module csfs_fault_timer #(
    parameter int CYCLES = 100000
) (
    input  wire logic clk_in,
    input  wire logic nrst_in,
    input  wire logic tick_in,
    input  wire logic count_en_in,
    output logic      expired_out
);
    localparam int CNT_W = $clog2(CYCLES + 1);

    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;

    if (CYCLES < 1) begin : g_bad
        $error("fault delay must be at least one cycle");
    end

    // ------------------------------------------------------------
    // Delay counter
    // ------------------------------------------------------------
    // Any return to regulation restarts the whole delay
    assign next_count = !count_en_in ? '0
                      : (tick_in && count != CYCLES[CNT_W-1:0]) ? count + 1'b1 : count;

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            count       <= '0;
            expired_out <= 1'b0;
        end else begin
            count       <= next_count;
            expired_out <= (next_count == CYCLES[CNT_W-1:0]);
        end
    end

    a_count_restart: assert property (@(posedge clk_in) disable iff (!nrst_in)
        !count_en_in |=> count == '0 && !expired_out)
        else $error("fault delay kept counting in regulation");

endmodule

// ==== hw/csfs_sequencer.sv ====
// Sequencing and supervision for a five-channel switching power unit.
// Assumes the analog stages report rail and regulation status synchronously.
`timescale 1ns/1ns

module csfs_sequencer #(
    parameter int SS_LEN    = 4096,
    parameter int BUCK_LEN  = 2048,
    parameter int FAULT_LEN = 100000
) (
    input  wire logic                        clk_in,
    input  wire logic                        nrst_in,
    input  wire logic                        boost_enable_in,
    input  wire logic                        main_enable_in,
    input  wire logic                        buck_enable_in,
    input  wire logic                        aux_a_enable_in,
    input  wire logic                        aux_b_enable_in,
    input  wire logic                        boost_rail_ok_in,
    input  wire logic [csfs_pkg::NUM_CH-1:0] in_reg_in,
    input  wire logic                        thermal_limit_in,
    input  wire logic                        timing_comp_in,
    output logic [csfs_pkg::NUM_CH-1:0]      channel_on_out,
    output logic                             startup_osc_out,
    output logic                             ref_enable_out,
    output logic                             discharge_out,
    output logic [csfs_pkg::REF_W-1:0]       main_ref_out,
    output logic [csfs_pkg::REF_W-1:0]       buck_ref_out,
    output logic [csfs_pkg::REF_W-1:0]       aux_a_ref_out,
    output logic [csfs_pkg::REF_W-1:0]       aux_b_ref_out,
    output logic                             fault_state_out,
    output logic                             buck_good_n_out,
    output logic                             buck_good_n_oe_out,
    output logic                             overload_flag_n_out,
    output logic                             overload_flag_n_oe_out
);
    import csfs_pkg::*;

    localparam int RETRY_W = $clog2(SS_LEN + 1);

    csfs_state_t          state;
    csfs_state_t          next_state;
    logic [SHOT_W-1:0]    shot_cnt;
    logic                 comp_q;
    logic                 osc_tick;
    logic [RETRY_W-1:0]   retry_cnt;
    logic                 retry_hit;
    logic                 uvlo_trip;
    logic                 next_uvlo_trip;
    logic [NUM_CH-1:0]    enables;
    logic [NUM_CH-1:0]    next_on;
    logic [NUM_CH-1:0]    ss_done;
    logic [NUM_CH-1:0]    fault_en;
    logic [NUM_CH-1:0]    expired;
    logic [REF_W-1:0]     ramp [NUM_CH];
    logic                 any_expired;
    logic                 boost_live;
    logic                 rail_lost;
    logic                 buck_good;

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (BUCK_LEN * 2 != SS_LEN) begin : g_bad
        $error("buck ramp must be half the standard ramp");
    end
    if (ONESHOT_CYC >= (1 << SHOT_W)) begin : g_bad_shot
        $error("discharge pulse does not fit its counter");
    end
    if (FAULT_LEN < 1 || SS_LEN < 2) begin : g_bad_len
        $error("ramp and fault lengths must be positive");
    end

    // ------------------------------------------------------------
    // Oscillator one-shot
    // ------------------------------------------------------------
    // Edges during the discharge pulse are ignored
    assign osc_tick = timing_comp_in && !comp_q && (shot_cnt == '0);

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            comp_q        <= 1'b0;
            shot_cnt      <= '0;
            discharge_out <= 1'b0;
        end else begin
            comp_q <= timing_comp_in;
            if (osc_tick) begin
                shot_cnt      <= SHOT_W'(ONESHOT_CYC);
                discharge_out <= 1'b1;
            end else if (shot_cnt != '0) begin
                shot_cnt      <= shot_cnt - 1'b1;
                discharge_out <= (shot_cnt > SHOT_W'(1));
            end
        end
    end

    // ------------------------------------------------------------
    // Boost supervisor
    // ------------------------------------------------------------
    assign enables     = {aux_b_enable_in, aux_a_enable_in, buck_enable_in,
                          main_enable_in, boost_enable_in};
    assign any_expired = |expired;
    assign rail_lost   = !boost_rail_ok_in;
    assign retry_hit   = (state == BST_WAIT) && osc_tick
                      && (retry_cnt == RETRY_W'(SS_LEN - 1));

    always_comb begin
        next_state = state;
        case (state)
            BST_OFF: begin
                if (boost_enable_in) begin
                    next_state = BST_START;
                end
            end
            BST_START: begin
                if (boost_rail_ok_in) begin
                    next_state = BST_WAIT;
                end
            end
            BST_WAIT: begin
                if (rail_lost || retry_hit) begin
                    next_state = BST_START;
                end else if (in_reg_in[CH_BOOST]) begin
                    next_state = BST_RUN;
                end
            end
            BST_RUN: begin
                if (rail_lost) begin
                    next_state = BST_START;
                end else if (any_expired) begin
                    next_state = BST_LATCH;
                end
            end
            BST_LATCH: begin
                next_state = BST_LATCH;
            end
            default: begin
                next_state = BST_OFF;
            end
        endcase
        if (!boost_enable_in) begin
            next_state = BST_OFF;
        end
    end

    // Trip is set by lockout or failed retry; set beats the clear
    assign next_uvlo_trip = ((state == BST_RUN) && rail_lost) || retry_hit
                         || (uvlo_trip && next_state != BST_RUN && next_state != BST_OFF);

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state     <= BST_OFF;
            retry_cnt <= '0;
            uvlo_trip <= 1'b0;
        end else begin
            state     <= next_state;
            uvlo_trip <= next_uvlo_trip;
            if (state != BST_WAIT || retry_hit) begin
                retry_cnt <= '0;
            end else if (osc_tick) begin
                retry_cnt <= retry_cnt + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Channel gating
    // ------------------------------------------------------------
    // Every state that keeps the boost switching
    function automatic logic boost_alive(input csfs_state_t s);
        return (s == BST_START) || (s == BST_WAIT) || (s == BST_RUN);
    endfunction

    // Boost runs in every live state; no ramp gates it
    assign boost_live = boost_alive(state);
    assign next_on[CH_BOOST] = boost_live;

    for (genvar i = 1; i < NUM_CH; i++) begin : g_dep
        assign next_on[i] = (state == BST_RUN) && enables[i] && boost_rail_ok_in;

        csfs_soft_start #(
            .CYCLES (i == CH_BUCK ? BUCK_LEN : SS_LEN),
            .REF_W  (REF_W)
        ) u_ramp (
            .clk_in    (clk_in),
            .nrst_in   (nrst_in),
            .tick_in   (osc_tick),
            .run_in    (channel_on_out[i]),
            .level_out (ramp[i]),
            .done_out  (ss_done[i])
        );
    end

    assign ramp[CH_BOOST]    = '0;
    assign ss_done[CH_BOOST] = (state == BST_RUN);

    for (genvar i = 0; i < NUM_CH; i++) begin : g_flt
        // Counting waits until the turn-on ramp has finished
        assign fault_en[i] = channel_on_out[i] && ss_done[i] && !in_reg_in[i];

        csfs_fault_timer #(
            .CYCLES (FAULT_LEN)
        ) u_timer (
            .clk_in      (clk_in),
            .nrst_in     (nrst_in),
            .tick_in     (osc_tick),
            .count_en_in (fault_en[i]),
            .expired_out (expired[i])
        );
    end

    assign main_ref_out  = ramp[CH_MAIN];
    assign buck_ref_out  = ramp[CH_BUCK];
    assign aux_a_ref_out = ramp[CH_AUX_A];
    assign aux_b_ref_out = ramp[CH_AUX_B];

    // ------------------------------------------------------------
    // Status pins and registered outputs
    // ------------------------------------------------------------
    // Thermal limit only floats the flag; the analog stage does the shutdown
    assign buck_good = channel_on_out[CH_BUCK] && ss_done[CH_BUCK]
                    && (state == BST_RUN) && !thermal_limit_in;

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            channel_on_out         <= '0;
            startup_osc_out        <= 1'b0;
            ref_enable_out         <= 1'b0;
            fault_state_out        <= 1'b0;
        end else begin
            channel_on_out         <= next_on;
            startup_osc_out        <= boost_enable_in && !boost_rail_ok_in;
            ref_enable_out         <= boost_enable_in && boost_rail_ok_in;
            fault_state_out        <= (state == BST_LATCH) || uvlo_trip;
        end
    end

    // ------------------------------------------------------------
    // Open-drain pins
    // ------------------------------------------------------------
    // Data stays low so a pin is only ever pulled down or released
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            buck_good_n_out        <= 1'b0;
            buck_good_n_oe_out     <= 1'b0;
            overload_flag_n_out    <= 1'b0;
            overload_flag_n_oe_out <= 1'b0;
        end else begin
            buck_good_n_out        <= 1'b0;
            buck_good_n_oe_out     <= buck_good;
            overload_flag_n_out    <= 1'b0;
            overload_flag_n_oe_out <= (state != BST_LATCH);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    a_latch_all_off: assert property (state == BST_LATCH |=> ##1 channel_on_out == '0)
        else $error("channel on while latched");
    a_latch_holds: assert property (state == BST_LATCH && boost_enable_in |=> state == BST_LATCH)
        else $error("latch cleared without boost enable");
    a_uvlo_drops_all: assert property ((state == BST_RUN) && rail_lost |-> ##2 channel_on_out[4:1] == '0)
        else $error("lockout did not drop channels");
    a_dep_hold: assert property (channel_on_out[4:1] != '0 |-> $past(state) == BST_RUN)
        else $error("dependent channel on before boost regulated");
    a_oneshot_width: assert property ($rose(discharge_out) |-> discharge_out [*4] ##1 !discharge_out)
        else $error("discharge pulse length wrong");
    a_ref_gate: assert property (ref_enable_out |-> $past(boost_enable_in) && $past(boost_rail_ok_in))
        else $error("reference enabled without boost rail");
    a_osc_handoff: assert property (boost_enable_in && boost_rail_ok_in |=> !startup_osc_out)
        else $error("startup oscillator kept after handoff");
    a_retry_trip: assert property (retry_hit && boost_enable_in |=> state == BST_START && uvlo_trip ##1 fault_state_out)
        else $error("failed retry did not refault");
    a_flag_float: assert property (state == BST_LATCH |=> !overload_flag_n_oe_out)
        else $error("overload flag still pulled low");
    a_good_after_ramp: assert property (buck_good_n_oe_out |-> $past(ss_done[CH_BUCK]))
        else $error("buck good before ramp end");
    a_boost_live: assert property (boost_alive(state) |=> channel_on_out[CH_BOOST])
        else $error("boost channel not switched in a live state");
    a_fault_shown: assert property (state == BST_LATCH |=> fault_state_out)
        else $error("fault state not shown while latched");
    a_expire_latch: assert property (state == BST_RUN && any_expired && boost_rail_ok_in && boost_enable_in
        |=> state == BST_LATCH)
        else $error("expired fault delay did not latch");
    a_off_clears: assert property (!boost_enable_in |=> state == BST_OFF)
        else $error("boost enable low did not clear the latch");
    a_dep_rail: assert property (!boost_rail_ok_in |=> channel_on_out[CH_AUX_B:CH_MAIN] == '0)
        else $error("dependent channel on with boost rail low");
    a_startup_osc: assert property (boost_enable_in && !boost_rail_ok_in |=> startup_osc_out)
        else $error("startup oscillator idle below lockout");
    a_thermal_float: assert property (thermal_limit_in |=> !buck_good_n_oe_out)
        else $error("buck good pulled low in thermal limit");

    c_latch: cover property (state == BST_RUN ##1 state == BST_LATCH);
    c_uvlo_retry: cover property (state == BST_RUN ##1 state == BST_START);
    c_buck_good: cover property ($rose(buck_good_n_oe_out));
    c_retry_fail: cover property (retry_hit);
    c_buck_ramp: cover property ($rose(ss_done[CH_BUCK]));

endmodule

// ==== tb/csfs_analog_model.sv ====
// Behavioural model of the analog stages: RC timing cap, boost rail, regulation.
// Assumes the sequencer's registered outputs and the bench's fault commands.
`timescale 1ns/1ns

module csfs_analog_model (
    input  wire logic       clk_in,
    input  wire logic       nrst_in,
    input  wire logic [4:0] channel_on_in,
    input  wire logic       discharge_in,
    input  wire logic       rail_short_in,
    input  wire logic [4:0] overload_in,
    output logic            rail_ok_out,
    output logic [4:0]      in_reg_out,
    output logic            comp_out
);
    logic [3:0] charge;
    logic [1:0] rise;

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            charge      <= 4'h0;
            comp_out    <= 1'b0;
            rise        <= 2'h0;
            rail_ok_out <= 1'b0;
            in_reg_out  <= 5'h00;
        end else begin
            // Cap charges only while the switch is open; comparator high until discharged
            charge   <= discharge_in ? 4'h0 : ((charge == 4'h3) ? charge : charge + 4'h1);
            comp_out <= !discharge_in && (charge == 4'h3);
            // Rail needs a few cycles of switching to pass lockout; a short holds it down
            rise        <= (channel_on_in[0] && !rail_short_in) ? ((rise == 2'h3) ? rise : rise + 2'h1) : 2'h0;
            rail_ok_out <= (rise == 2'h3) && !rail_short_in;
            in_reg_out  <= {channel_on_in[4:1] & ~overload_in[4:1],
                            rail_ok_out & channel_on_in[0] & ~overload_in[0]};
        end
    end
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the converter sequencer with the analog model.
// Assumes shortened counts: ramp 16, buck ramp 8, fault delay 20 ticks.
`timescale 1ns/1ns

module testbench;
    import csfs_pkg::*;
    localparam int SS = 16;
    localparam int BK = 8;
    localparam int FL = 20;
    logic        clk_in = 1'b0;
    logic        nrst_in = 1'b0;
    logic [4:0]  en = 5'h00;
    logic [4:0]  ovl = 5'h00;
    logic        short_rail = 1'b0;
    logic        thermal = 1'b0;
    logic        rail_ok;
    logic        comp;
    logic [4:0]  in_reg;
    logic [4:0]  chan;
    logic        osc, ref_en, dis, fault, bg, bg_oe, of, of_oe;
    logic [11:0] mref, bref, aref, xref;
    int          mismatches = 0;
    int          tests_run = 0;
    int          cycles = 0;
    int          len = 0;

    always #25 clk_in = ~clk_in;

    csfs_sequencer #(.SS_LEN(SS), .BUCK_LEN(BK), .FAULT_LEN(FL)) i_dut (
        .clk_in(clk_in), .nrst_in(nrst_in), .boost_enable_in(en[0]), .main_enable_in(en[1]),
        .buck_enable_in(en[2]), .aux_a_enable_in(en[3]), .aux_b_enable_in(en[4]),
        .boost_rail_ok_in(rail_ok), .in_reg_in(in_reg), .thermal_limit_in(thermal),
        .timing_comp_in(comp), .channel_on_out(chan), .startup_osc_out(osc),
        .ref_enable_out(ref_en), .discharge_out(dis), .main_ref_out(mref), .buck_ref_out(bref),
        .aux_a_ref_out(aref), .aux_b_ref_out(xref), .fault_state_out(fault),
        .buck_good_n_out(bg), .buck_good_n_oe_out(bg_oe), .overload_flag_n_out(of),
        .overload_flag_n_oe_out(of_oe));

    csfs_analog_model i_model (
        .clk_in(clk_in), .nrst_in(nrst_in), .channel_on_in(chan), .discharge_in(dis),
        .rail_short_in(short_rail), .overload_in(ovl), .rail_ok_out(rail_ok),
        .in_reg_out(in_reg), .comp_out(comp));

    task automatic chk(input logic [11:0] e, input logic [11:0] a);
        tests_run++;
        if (a !== e) begin
            mismatches++;
            $display("Error at %0t: expected %h got %h", $time, e, a);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
        #5;
    endtask

    task automatic final_report;
        $display("mismatches %0d, comparisons %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Hang guard: the whole sequence needs about two thousand cycles
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            final_report();
        end
    end

    always @(negedge clk_in) begin
        if (dis === 1'b1) len++;
        else if (len != 0) begin
            chk(ONESHOT_CYC, len);
            len = 0;
        end
    end

    initial begin
        int mt, bt, cnt, r;
        logic pd;
        void'($urandom(32'h8d38));
        step(8);
        chk(5'h00, chan);
        nrst_in = 1'b1;
        step(2);
        chk(1, of_oe);
        $display("test reset done");
        // Dependents requested early must wait for the boost
        en = 5'h1f;
        step(2);
        chk(5'h01, chan);
        chk(1, osc);
        chk(0, ref_en);
        for (int i = 0; i < 50 && chan[1] !== 1'b1; i++) step(1);
        chk(1, ref_en);
        chk(0, osc);
        mt = 0; bt = 0; cnt = 0; pd = dis;
        for (int i = 0; i < 2000 && (mt == 0 || bt == 0); i++) begin
            step(1);
            if (dis === 1'b1 && pd === 1'b0) begin
                cnt++;
                if (cnt < SS) chk(cnt * (4096 / SS), mref);
                if (cnt < SS) chk(cnt * (4096 / SS), aref);
                if (cnt < SS) chk(cnt * (4096 / SS), xref);
                if (cnt < BK) chk(cnt * (4096 / BK), bref);
            end
            pd = dis;
            if (bt == 0 && bref === 12'hfff) bt = cnt;
            if (mt == 0 && mref === 12'hfff) mt = cnt;
        end
        chk(SS, mt);
        chk(BK, bt);
        step(3);
        chk(1, bg_oe);
        chk(0, bg);
        chk(0, of);
        thermal = 1'b1;
        step(3);
        chk(0, bg_oe);
        thermal = 1'b0;
        $display("test bring_up done");
        for (int k = 0; k < 6; k++) begin
            r = $urandom;
            en = {r[3:0], 1'b1};
            step(4);
            chk({r[3:0], 1'b1}, chan);
        end
        en = 5'h1f;
        step(200);
        $display("test random_enables done");
        // Short excursion restarts the delay count
        ovl[3] = 1'b1;
        step(108);
        ovl[3] = 1'b0;
        step(20);
        ovl[3] = 1'b1;
        step(108);
        chk(0, fault);
        step(150);
        chk(1, fault);
        chk(5'h00, chan);
        chk(0, of_oe);
        chk(0, bg_oe);
        ovl = 5'h00;
        step(300);
        chk(1, fault);
        en[0] = 1'b0;
        step(3);
        en[0] = 1'b1;
        step(300);
        chk(0, fault);
        chk(1, of_oe);
        chk(5'h1f, chan);
        $display("test overload done");
        short_rail = 1'b1;
        step(5);
        chk(1, fault);
        chk(5'h01, chan);
        chk(1, osc);
        // Main out of regulation through its ramp must not count
        short_rail = 1'b0;
        ovl[1] = 1'b1;
        step(300);
        chk(0, fault);
        chk(5'h1f, chan);
        ovl[1] = 1'b0;
        $display("test lockout done");
        // Rail comes up but boost never regulates
        en[0] = 1'b0;
        ovl[0] = 1'b1;
        step(3);
        en[0] = 1'b1;
        step(20);
        chk(0, fault);
        step(200);
        chk(1, fault);
        chk(5'h01, chan);
        $display("test retry done");
        final_report();
    end
endmodule
